// ==== common/tws_pkg.sv ====
// Purpose: shared constants and types of the two-wire memory slave and its master
// Assumes: 200 MHz system clock on both ends
// Notes: times are given in their own unit; cycle counts derive from them
package tws_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
  // Device addressing
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [7:0] MAIN_ADDR_DEFAULT = 8'hA2;
  localparam logic [7:0] AUX_ADDR = 8'hA0;
  localparam logic [7:0] DEVADDR_LOC = 8'h8C;
  localparam logic [7:0] CFG_LOC = 8'h89;
  localparam int CFG_SINGLE_BIT = 5;
  localparam int CFG_FIXED_BIT = 4;
  // Volatile main-space window and the flags living in it
  localparam logic [7:0] VOL_LO = 8'h60;
  localparam logic [7:0] VOL_HI = 8'h7F;
  localparam logic [7:0] TEMP_MSB_LOC = 8'h60;
  localparam logic [7:0] TEMP_LSB_LOC = 8'h61;
  localparam logic [7:0] STATUS_LOC = 8'h6E;
  localparam int NOT_READY_BIT = 0;
  localparam logic [7:0] ALARM_LOC = 8'h70;
  localparam int VCC_ALARM_BIT = 4;
  localparam int PAGE_BYTES = 8;
  // Lookup indexing: 2 degree steps from -40 to +102
  localparam int LUT_BASE_C = 40;
  localparam logic [6:0] LUT_MAX_IDX = 7'h47;
  // Times
  localparam int NVM_WRITE_US = 10000;
  localparam int NVM_WRITE_CYCLES = NVM_WRITE_US * CLK_MHZ;
  localparam int FRAME_US = 64000;
  localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
  localparam int READY_US = 2000;
  localparam int READY_CYCLES = READY_US * CLK_MHZ;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_MACK} tws_slv_state_e;
  typedef enum logic [1:0] {RL_DEV, RL_MEM, RL_DATA} tws_role_e;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} tws_mst_state_e;
endpackage : tws_pkg

// ==== common/tws_if.sv ====
// Purpose: open-drain two-wire bus joining master and slave
// Assumes: pull-ups on both lines
// Notes: a line is low when any enabled driver drives 0
interface tws_if;
  logic scl_m_out;
  logic scl_m_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_m_oe & ~scl_m_out);
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));
  modport master (output scl_m_out, output scl_m_oe, output sda_m_out, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_out, output sda_s_oe, input scl, input sda);
endinterface : tws_if

// ==== core/tws_buf.sv ====
// Purpose: two-entry valid/ready buffer
// Assumes: single clock
// Notes: head entry is a register, so out_data comes straight from a flop
module tws_buf #(
  parameter int WIDTH = 8
) (
  // System
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic v0;
    logic v1;
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
  } tws_buf_s;
  tws_buf_s s;
  tws_buf_s next_s;

  always_comb
  begin
    next_s = s;
    if (s.v0 && out_ready)
    begin
      next_s.v0 = s.v1;
      next_s.d0 = s.d1;
      next_s.v1 = 1'b0;
    end
    // Full refuses the word; the filler must hold it
    if (in_valid && !s.v1)
    begin
      if (!next_s.v0)
      begin
        next_s.v0 = 1'b1;
        next_s.d0 = in_data;
      end
      else
      begin
        next_s.v1 = 1'b1;
        next_s.d1 = in_data;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign in_ready = ~s.v1;
  assign out_valid = s.v0;
  assign out_data = s.d0;
endmodule : tws_buf

// ==== core/tws_slave.sv ====
// Purpose: two-wire slave giving a bus master access to a byte memory
// Assumes: scl, sda and supply levels are asynchronous; temperature inputs share the clock
// Notes: lines are oversampled, so SCL must stay high and low for several clocks
// Contract
// - Convert temperature each frame into 60h/61h
// - No conversion while a serial access runs
// - 2 degree lookup steps, 1 degree hysteresis
// - Serial works above digital threshold; recall above analog
// - Not-ready flag clears after delay, sets below analog
// - Recalled values kept until below digital threshold
// - Main address A2h until recall completes
// - Auxiliary A0h always answers before recall
// - Supply alarm reads 1 until first conversion
// - Start and stop are SDA edges while SCL high
// - Standby after power-on, stop, finished operations
// - Acknowledge every accepted byte on ninth clock
// - Address byte 1010xxx plus R/W, MSB first
// - Match acknowledges and selects; mismatch goes idle
// - Byte write: address, data, stop, timed commit
// - Page write up to eight bytes per page
// - Write address wraps inside its 8-byte page
// - Page data commits only on stop
// - No address acknowledge during the write cycle
// - Address register holds last address plus one
// - Random read is dummy write then read
// - Sequential read wraps FFh to 00h; nack ends
// - Bytes 60h-7Fh volatile and never protected
module tws_slave #(
  parameter int NVM_WRITE_CYCLES = tws_pkg::NVM_WRITE_CYCLES,
  parameter int FRAME_CYCLES = tws_pkg::FRAME_CYCLES,
  parameter int READY_CYCLES = tws_pkg::READY_CYCLES
) (
  // System
  input wire logic clock,
  input wire logic reset,
  // Two-wire bus
  tws_if.slave bus,
  // Supply monitors
  input wire logic digital_por_threshold,
  input wire logic analog_por_threshold,
  // Conversion results
  input wire logic [15:0] temp_sample,
  input wire logic vcc_conv_done,
  input wire logic vcc_alarm_in,
  // Status
  output logic [6:0] lut_index,
  output logic conversion_not_ready_flag,
  output logic nvm_busy,
  output logic standby
);
  typedef struct packed {
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, pod_m, pod_s, poa_m, poa_s;
    tws_pkg::tws_slv_state_e st;
    tws_pkg::tws_role_e role;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rd, sel, mack_ok, sda_oe;
    logic [7:0] addr;
    logic busy;
    logic [31:0] wcnt;
    logic [4:0] page_base;
    logic page_sel;
    logic [7:0][7:0] pbuf;
    logic [7:0] pmask;
    logic recalled, single_address_mode, address_from_nvm_select;
    logic [7:0] main_addr;
    logic rdy_n, alarm, conv_pend, standby;
    logic [31:0] rdy_cnt;
    logic [31:0] frame_cnt;
    logic [6:0] lut;
  } tws_slave_s;

  // Line samplers start at the released level, so leaving reset shows no false edge
  localparam tws_slave_s S_RST = '{st: tws_pkg::SL_IDLE, role: tws_pkg::RL_DEV,
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    main_addr: tws_pkg::MAIN_ADDR_DEFAULT, rdy_n: 1'b1, alarm: 1'b1, standby: 1'b1, default: '0};

  tws_slave_s s;
  tws_slave_s next_s;
  logic [7:0] mem [0:511];
  logic scl_rise, scl_fall, start_c, stop_c, commit, vol_we, temp_we;
  logic [7:0] main_eff;
  logic main_hit, aux_hit, vol_addr;

  function automatic logic [7:0] read_byte(input logic sel, input logic [7:0] a);
    logic [7:0] b;
    b = mem[{sel, a}];
    if (!sel && a == tws_pkg::STATUS_LOC)
      b[tws_pkg::NOT_READY_BIT] = s.rdy_n;
    if (!sel && a == tws_pkg::ALARM_LOC)
      b[tws_pkg::VCC_ALARM_BIT] = s.alarm;
    return b;
  endfunction : read_byte

  // Move the index straight to the target step; except for the first and last steps, the degree of that step nearest the old index stops one short
  function automatic logic [6:0] lut_step(input logic [6:0] idx, input logic [7:0] t_byte);
    logic signed [9:0] rel;
    logic [6:0] raw;
    logic [6:0] res;
    rel = $signed({{2{t_byte[7]}}, t_byte}) + 10'sd40;
    res = idx;
    if (rel < 10'sd0)
      raw = 7'h00;
    else if (rel > $signed({2'b00, tws_pkg::LUT_MAX_IDX, 1'b1}))
      raw = tws_pkg::LUT_MAX_IDX;
    else
      raw = rel[7:1];
    if (raw > idx)
      res = (rel[0] || raw == tws_pkg::LUT_MAX_IDX) ? raw : 7'(raw - 7'h01);
    else if (raw < idx)
      res = (rel[0] && raw != 7'h00) ? 7'(raw + 7'h01) : raw;
    return res;
  endfunction : lut_step

  always_comb
  begin
    next_s = s;
    commit = 1'b0;
    vol_we = 1'b0;
    temp_we = 1'b0;
    next_s.scl_m = bus.scl;
    next_s.scl_s = s.scl_m;
    next_s.scl_d = s.scl_s;
    next_s.sda_m = bus.sda;
    next_s.sda_s = s.sda_m;
    next_s.sda_d = s.sda_s;
    next_s.pod_m = digital_por_threshold;
    next_s.pod_s = s.pod_m;
    next_s.poa_m = analog_por_threshold;
    next_s.poa_s = s.poa_m;
    scl_rise = s.scl_s & ~s.scl_d;
    scl_fall = ~s.scl_s & s.scl_d;
    start_c = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
    stop_c = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
    main_eff = (s.recalled && s.address_from_nvm_select) ? s.main_addr : tws_pkg::MAIN_ADDR_DEFAULT;
    main_hit = s.sh[7:4] == tws_pkg::DEV_TYPE && s.sh[7:1] == main_eff[7:1];
    aux_hit = s.sh[7:4] == tws_pkg::DEV_TYPE && s.sh[7:1] == tws_pkg::AUX_ADDR[7:1]
      && (!s.recalled || !s.single_address_mode);
    vol_addr = !s.sel && s.addr >= tws_pkg::VOL_LO && s.addr <= tws_pkg::VOL_HI;
    if (!s.pod_s)
    begin
      // Below the digital threshold all slave state except the line and supply samplers returns to reset; the memory array keeps its contents
      next_s = S_RST;
      next_s.scl_m = bus.scl;
      next_s.scl_s = s.scl_m;
      next_s.scl_d = s.scl_s;
      next_s.sda_m = bus.sda;
      next_s.sda_s = s.sda_m;
      next_s.sda_d = s.sda_s;
      next_s.pod_m = digital_por_threshold;
      next_s.pod_s = s.pod_m;
      next_s.poa_m = analog_por_threshold;
      next_s.poa_s = s.poa_m;
    end
    else
    begin
      if (!s.poa_s)
      begin
        next_s.rdy_n = 1'b1;
        next_s.rdy_cnt = '0;
      end
      else
      begin
        if (!s.recalled)
        begin
          next_s.recalled = 1'b1;
          next_s.main_addr = mem[{1'b0, tws_pkg::DEVADDR_LOC}];
          next_s.single_address_mode = mem[{1'b0, tws_pkg::CFG_LOC}][tws_pkg::CFG_SINGLE_BIT];
          next_s.address_from_nvm_select = mem[{1'b0, tws_pkg::CFG_LOC}][tws_pkg::CFG_FIXED_BIT];
        end
        if (s.rdy_n)
        begin
          if (s.rdy_cnt == 32'(READY_CYCLES - 1))
            next_s.rdy_n = 1'b0;
          else
            next_s.rdy_cnt = s.rdy_cnt + 32'h1;
        end
      end
      if (vcc_conv_done)
        next_s.alarm = vcc_alarm_in;
      // A frame falling inside an access waits for the slave to return to SL_IDLE with no start that cycle
      if (s.conv_pend && s.st == tws_pkg::SL_IDLE && !start_c)
      begin
        temp_we = 1'b1;
        next_s.conv_pend = 1'b0;
        next_s.lut = lut_step(s.lut, temp_sample[15:8]);
      end
      // Frame tick comes after the clear so a frame ending in the same cycle as the clear is not lost
      if (!s.rdy_n)
      begin
        if (s.frame_cnt == 32'(FRAME_CYCLES - 1))
        begin
          next_s.frame_cnt = '0;
          next_s.conv_pend = 1'b1;
        end
        else
          next_s.frame_cnt = s.frame_cnt + 32'h1;
      end
      if (s.busy)
      begin
        if (s.wcnt == 32'(NVM_WRITE_CYCLES - 1))
        begin
          commit = 1'b1;
          next_s.busy = 1'b0;
          next_s.wcnt = '0;
          next_s.pmask = '0;
        end
        else
          next_s.wcnt = s.wcnt + 32'h1;
      end
      if (stop_c)
      begin
        if (s.pmask != 8'h00 && !s.busy)
          next_s.busy = 1'b1;
        next_s.st = tws_pkg::SL_IDLE;
        next_s.sda_oe = 1'b0;
      end
      else if (start_c)
      begin
        next_s.st = tws_pkg::SL_RX;
        next_s.role = tws_pkg::RL_DEV;
        next_s.cnt = '0;
        next_s.sda_oe = 1'b0;
        if (!s.busy)
          next_s.pmask = '0;
      end
      else
      begin
        unique case (s.st)
          tws_pkg::SL_IDLE:
          begin
          end
          tws_pkg::SL_RX:
          begin
            if (scl_rise && s.cnt != 4'h8)
            begin
              next_s.sh = {s.sh[6:0], s.sda_s};
              next_s.cnt = s.cnt + 4'h1;
            end
            else if (scl_fall && s.cnt == 4'h8)
            begin
              next_s.st = tws_pkg::SL_ACK;
              next_s.sda_oe = 1'b1;
              unique case (s.role)
                tws_pkg::RL_DEV:
                begin
                  if ((main_hit || aux_hit) && !s.busy)
                  begin
                    next_s.rd = s.sh[0];
                    next_s.sel = aux_hit && !main_hit;
                  end
                  else
                  begin
                    next_s.st = tws_pkg::SL_IDLE;
                    next_s.sda_oe = 1'b0;
                  end
                end
                tws_pkg::RL_MEM:
                  next_s.addr = s.sh;
                default:
                begin
                  if (vol_addr)
                    vol_we = 1'b1;
                  else
                  begin
                    next_s.pbuf[s.addr[2:0]] = s.sh;
                    next_s.pmask[s.addr[2:0]] = 1'b1;
                    next_s.page_base = s.addr[7:3];
                    next_s.page_sel = s.sel;
                  end
                  next_s.addr = {s.addr[7:3], 3'(s.addr[2:0] + 3'h1)};
                end
              endcase
            end
          end
          tws_pkg::SL_ACK:
          begin
            if (scl_fall)
            begin
              next_s.cnt = '0;
              if (s.rd)
              begin
                next_s.sh = read_byte(s.sel, s.addr);
                next_s.sda_oe = ~next_s.sh[7];
                next_s.st = tws_pkg::SL_TX;
              end
              else
              begin
                next_s.sda_oe = 1'b0;
                next_s.st = tws_pkg::SL_RX;
                next_s.role = (s.role == tws_pkg::RL_DEV) ? tws_pkg::RL_MEM : tws_pkg::RL_DATA;
              end
            end
          end
          tws_pkg::SL_TX:
          begin
            if (scl_fall)
            begin
              if (s.cnt == 4'h7)
              begin
                next_s.sda_oe = 1'b0;
                next_s.st = tws_pkg::SL_MACK;
                next_s.addr = s.addr + 8'h01;
              end
              else
              begin
                next_s.sh = {s.sh[6:0], 1'b0};
                next_s.sda_oe = ~s.sh[6];
                next_s.cnt = s.cnt + 4'h1;
              end
            end
          end
          tws_pkg::SL_MACK:
          begin
            if (scl_rise)
              next_s.mack_ok = ~s.sda_s;
            else if (scl_fall)
            begin
              if (s.mack_ok)
              begin
                next_s.sh = read_byte(s.sel, s.addr);
                next_s.sda_oe = ~next_s.sh[7];
                next_s.cnt = '0;
                next_s.st = tws_pkg::SL_TX;
              end
              else
                next_s.st = tws_pkg::SL_IDLE;
            end
          end
          default:
            next_s.st = tws_pkg::SL_IDLE;
        endcase
      end
    end
    next_s.standby = next_s.st == tws_pkg::SL_IDLE && !next_s.busy && !next_s.conv_pend;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s <= S_RST;
    else
      s <= next_s;
  end

  // Nonvolatile image and volatile window share one array; no reset on storage
  always_ff @(posedge clock)
  begin
    if (commit)
    begin
      for (int i = 0; i < tws_pkg::PAGE_BYTES; i++)
      begin
        if (s.pmask[i])
          mem[{s.page_sel, s.page_base, 3'(i)}] <= s.pbuf[i];
      end
    end
    if (vol_we)
      mem[{1'b0, s.addr}] <= s.sh;
    if (temp_we)
    begin
      mem[{1'b0, tws_pkg::TEMP_MSB_LOC}] <= temp_sample[15:8];
      mem[{1'b0, tws_pkg::TEMP_LSB_LOC}] <= temp_sample[7:0];
    end
  end

  assign bus.sda_s_out = 1'b0;
  assign bus.sda_s_oe = s.sda_oe;
  assign lut_index = s.lut;
  assign conversion_not_ready_flag = s.rdy_n;
  assign nvm_busy = s.busy;
  assign standby = s.standby;
endmodule : tws_slave

// ==== core/tws_master.sv ====
// Purpose: byte-level two-wire bus master with a buffered read path
// Assumes: no clock stretching by the slave
// Notes: a full read buffer holds SCL low before the acknowledge bit
module tws_master #(
  parameter int QUARTER_CYCLES = tws_pkg::SCL_QUARTER_CYCLES
) (
  // System
  input wire logic clock,
  input wire logic reset,
  // Two-wire bus
  tws_if.master bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_wdata,
  // Response
  output logic rsp_done,
  output logic rsp_ack,
  // Read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  typedef struct packed {
    tws_pkg::tws_mst_state_e st;
    logic [1:0] ph;
    logic [15:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd, nack, stop, scl_oe, sda_oe, sda_m, sda_s, ready, done, ack;
  } tws_master_s;

  tws_master_s s;
  tws_master_s next_s;
  logic tick, push, buf_ready, advance;

  always_comb
  begin
    next_s = s;
    next_s.sda_m = bus.sda;
    next_s.sda_s = s.sda_m;
    next_s.done = 1'b0;
    tick = s.qcnt == 16'(QUARTER_CYCLES - 1);
    next_s.qcnt = (tick || s.st == tws_pkg::MS_IDLE) ? 16'h0 : s.qcnt + 16'h1;
    push = tick && s.st == tws_pkg::MS_BIT && s.ph == 2'h0 && s.bitn == 4'h8 && s.rd && buf_ready;
    advance = tick && !(s.st == tws_pkg::MS_BIT && s.ph == 2'h0 && s.bitn == 4'h8 && s.rd && !buf_ready);
    if (!advance)
      next_s.qcnt = tick ? s.qcnt : next_s.qcnt;
    unique case (s.st)
      tws_pkg::MS_IDLE:
      begin
        if (cmd_valid && s.ready)
        begin
          next_s.ready = 1'b0;
          next_s.sh = cmd_wdata;
          next_s.rd = cmd_read;
          next_s.nack = cmd_nack;
          next_s.stop = cmd_stop;
          next_s.ph = 2'h0;
          next_s.bitn = 4'h0;
          next_s.st = cmd_start ? tws_pkg::MS_START : tws_pkg::MS_BIT;
        end
      end
      tws_pkg::MS_START:
      begin
        if (advance)
        begin
          next_s.ph = s.ph + 2'h1;
          unique case (s.ph)
            2'h0: next_s.sda_oe = 1'b0;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b1;
            default:
            begin
              next_s.scl_oe = 1'b1;
              next_s.st = tws_pkg::MS_BIT;
            end
          endcase
        end
      end
      tws_pkg::MS_BIT:
      begin
        if (advance)
        begin
          next_s.ph = s.ph + 2'h1;
          unique case (s.ph)
            2'h0:
            begin
              // Data changes only with SCL low
              if (s.bitn != 4'h8)
                next_s.sda_oe = !s.rd && !s.sh[7];
              else
                next_s.sda_oe = s.rd && !s.nack;
            end
            2'h1: next_s.scl_oe = 1'b0;
            2'h2:
            begin
              if (s.bitn != 4'h8)
                next_s.sh = {s.sh[6:0], s.sda_s};
              else if (!s.rd)
                next_s.ack = ~s.sda_s;
            end
            default:
            begin
              next_s.scl_oe = 1'b1;
              next_s.bitn = s.bitn + 4'h1;
              if (s.bitn == 4'h8)
              begin
                next_s.sda_oe = 1'b0;
                next_s.st = s.stop ? tws_pkg::MS_STOP : tws_pkg::MS_IDLE;
                next_s.ready = !s.stop;
                next_s.done = !s.stop;
              end
            end
          endcase
        end
      end
      default:
      begin
        if (advance)
        begin
          next_s.ph = s.ph + 2'h1;
          unique case (s.ph)
            2'h0: next_s.sda_oe = 1'b1;
            2'h1: next_s.scl_oe = 1'b0;
            2'h2: next_s.sda_oe = 1'b0;
            default:
            begin
              next_s.st = tws_pkg::MS_IDLE;
              next_s.ready = 1'b1;
              next_s.done = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s <= '{st: tws_pkg::MS_IDLE, ready: 1'b1, sda_m: 1'b1, sda_s: 1'b1, default: '0};
    else
      s <= next_s;
  end

  tws_buf #(
    .WIDTH(8)
  ) u_rd_buf (
    .clock(clock),
    .reset(reset),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(s.sh),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign bus.scl_m_out = 1'b0;
  assign bus.scl_m_oe = s.scl_oe;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe = s.sda_oe;
  assign cmd_ready = s.ready;
  assign rsp_done = s.done;
  assign rsp_ack = s.ack;
endmodule : tws_master

// ==== verif/tws_checker_sva.sv ====
// Purpose: wire-level checks of the two-wire link
// Assumes: one clock domain, lines sampled raw
// Notes: the slave driver is judged here, plus minimum SCL high and low times
module tws_checker (
  // System
  input wire logic clock,
  input wire logic reset,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_out,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  property p_edge_low;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("slave sda moved, scl high");
  property p_ack_hold;
    scl && sda_s_oe |=> sda_s_oe || !scl;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("slave low not held");
  property p_drive_zero;
    sda_s_oe |-> !sda_s_out;
  endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("slave drives high");
  property p_high_min;
    $rose(scl) |-> scl [*4];
  endproperty
  a_high_min: assert property (p_high_min) else $error("scl high too short");
  property p_low_min;
    $fell(scl) |-> !scl [*4];
  endproperty
  a_low_min: assert property (p_low_min) else $error("scl low too short");
  property p_listen;
    s_start |-> !sda_s_oe [*8];
  endproperty
  a_listen: assert property (p_listen) else $error("slave drives after start");
  property p_stop_quiet;
    s_stop |=> !sda_s_oe [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("slave drives after stop");
  property p_no_slave_cond;
    scl && $past(scl) && $changed(sda) |-> !$past(sda_s_oe);
  endproperty
  a_no_slave_cond: assert property (p_no_slave_cond) else $error("slave made a condition");
endmodule : tws_checker

// ==== verif/two_wire_slave_memory_access_test.sv ====
// Purpose: master and slave joined, driven from the command side
// Assumes: short nvm, frame and ready counts
// Notes: scenarios share memory contents and run in order
module two_wire_slave_memory_access_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] S = 4'h8;
  localparam logic [3:0] P = 4'h4;
  localparam logic [3:0] R = 4'h2;
  localparam logic [3:0] N = 4'h1;
  localparam logic [7:0] WA = tws_pkg::MAIN_ADDR_DEFAULT;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic por_d = 1'b0;
  logic por_a = 1'b0;
  logic valid = 1'b0;
  logic [3:0] fl = 4'h0;
  logic [7:0] wd = 8'h00;
  logic rd_ready = 1'b0;
  logic conv = 1'b0;
  logic alarm_in = 1'b0;
  logic ready, done, ack, rd_valid, busy, nrdy, stby;
  logic [7:0] rd_data;
  logic [6:0] lut;
  int err_total = 0;
  int samples_checked = 0;
  tws_if bus_if ();
  always #2.5 clock = ~clock;
  tws_master #(.QUARTER_CYCLES(8)) u_tws_master (.clock(clock), .reset(reset), .bus(bus_if.master),
    .cmd_valid(valid), .cmd_ready(ready), .cmd_start(fl[3]), .cmd_stop(fl[2]), .cmd_read(fl[1]),
    .cmd_nack(fl[0]), .cmd_wdata(wd), .rsp_done(done), .rsp_ack(ack), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  tws_slave #(.NVM_WRITE_CYCLES(2000), .FRAME_CYCLES(300), .READY_CYCLES(50)) u_tws_slave (.clock(clock),
    .reset(reset), .bus(bus_if.slave), .digital_por_threshold(por_d), .analog_por_threshold(por_a),
    .temp_sample(16'h1980), .vcc_conv_done(conv), .vcc_alarm_in(alarm_in), .lut_index(lut),
    .conversion_not_ready_flag(nrdy), .nvm_busy(busy), .standby(stby));
  tws_checker u_tws_checker (.clock(clock), .reset(reset), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_out(bus_if.sda_s_out), .sda_s_oe(bus_if.sda_s_oe));
  task automatic complete_run;
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [3:0] f, input logic [7:0] d);
    int n;
    fl <= f;
    wd <= d;
    valid <= 1'b1;
    for (n = 0; n == 0 || (n < 99 && ready !== 1'b1); n++) @(posedge clock);
    chk({7'h0, ready}, 8'h01);
    valid <= 1'b0;
    for (n = 0; n == 0 || (n < 4000 && done !== 1'b1); n++) @(posedge clock);
    chk({7'h0, done}, 8'h01);
  endtask : send
  task automatic wr(input logic [3:0] f, input logic [7:0] d, input logic a);
    send(f, d);
    chk({7'h0, ack}, {7'h0, a});
  endtask : wr
  task automatic pop(input logic [7:0] e);
    int n;
    for (n = 0; n == 0 || (n < 4000 && rd_valid !== 1'b1); n++) @(posedge clock);
    // Take exactly one word, then let an edge pass before the next pop
    rd_ready <= 1'b1;
    @(posedge clock);
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, e);
    rd_ready <= 1'b0;
    @(posedge clock);
  endtask : pop
  // Dummy write of the pointer, then repeated start for reading
  task automatic point(input logic [7:0] a);
    wr(S, WA, 1'b1);
    wr(4'h0, a, 1'b1);
    wr(S, WA | 8'h01, 1'b1);
  endtask : point
  task automatic sc_power;
    int n;
    chk({6'h0, stby, nrdy}, 8'h03);
    wr(S | P, tws_pkg::AUX_ADDR, 1'b1);
    wr(S | P, 8'hA4, 1'b0);
    // Config byte is unknown until written, so clear it before recall
    wr(S, WA, 1'b1);
    wr(4'h0, tws_pkg::CFG_LOC, 1'b1);
    wr(P, 8'h00, 1'b1);
    repeat (8) @(posedge clock);
    chk({7'h0, busy}, 8'h01);
    wr(S | P, WA, 1'b0);
    for (n = 0; n < 9000 && busy !== 1'b0; n++) @(posedge clock);
    wr(S | P, WA, 1'b1);
    por_a <= 1'b1;
    for (n = 0; n == 0 || (n < 999 && nrdy !== 1'b0); n++) @(posedge clock);
    chk({6'h0, n >= 50, nrdy}, 8'h02);
    por_a <= 1'b0;
    repeat (8) @(posedge clock);
    chk({7'h0, nrdy}, 8'h01);
    por_a <= 1'b1;
  endtask : sc_power
  task automatic sc_vol;
    wr(S, WA, 1'b1);
    wr(4'h0, 8'h62, 1'b1);
    wr(4'h0, 8'h5A, 1'b1);
    wr(4'h0, 8'h5B, 1'b1);
    wr(P, 8'h5C, 1'b1);
    repeat (8) @(posedge clock);
    chk({7'h0, busy}, 8'h00);
    point(8'h62);
    send(R, 8'h00);
    send(R, 8'h00);
    fork
      send(R | N | P, 8'h00);
      begin
        repeat (40) @(posedge clock);
        pop(8'h5A);
        pop(8'h5B);
        pop(8'h5C);
      end
    join
    point(tws_pkg::TEMP_MSB_LOC);
    send(R | N | P, 8'h00);
    pop(8'h19);
    chk({1'b0, lut}, 8'h20);
  endtask : sc_vol
  // Alarm reads 1 until the first supply result, then follows each result
  task automatic sc_alarm;
    wr(S, WA, 1'b1);
    wr(4'h0, tws_pkg::ALARM_LOC, 1'b1);
    wr(P, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      point(tws_pkg::ALARM_LOC);
      send(R | N | P, 8'h00);
      pop(i == 1 ? 8'h00 : 8'h10);
      alarm_in <= (i == 1);
      conv <= 1'b1;
      @(posedge clock);
      conv <= 1'b0;
    end
  endtask : sc_alarm
  task automatic sc_page;
    int i;
    wr(S, WA, 1'b1);
    wr(4'h0, 8'h06, 1'b1);
    for (i = 0; i < 8; i++) wr(4'h0, 8'h10 + i[7:0], 1'b1);
    wr(P, 8'h18, 1'b1);
    repeat (8) @(posedge clock);
    for (i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clock);
    point(8'h00);
    for (i = 0; i < 7; i++)
    begin
      send(i == 6 ? R | N | P : R, 8'h00);
      pop(8'h12 + i[7:0]);
    end
    wr(S, WA | 8'h01, 1'b1);
    send(R | N | P, 8'h00);
    pop(8'h11);
  endtask : sc_page
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    por_d <= 1'b1;
    repeat (8) @(posedge clock);
    sc_power;
    sc_vol;
    sc_alarm;
    sc_page;
    complete_run;
  end
  initial
  begin
    #400000;
    err_total++;
    complete_run;
  end
endmodule : two_wire_slave_memory_access_test
